// ---- bms_pkg.sv ----
// Package of constants and types for the backplane memory slave interface
package bms_pkg;
    localparam int          ADDR_W        = 22;
    localparam int          DATA_W        = 16;
    localparam int          MEM_AW        = 8;
    localparam int          MEM_DEPTH     = 256;
    localparam int          CLK_PERIOD_NS = 25;
    localparam int          DATA_VALID_NS = 125;
    localparam int          DATA_VALID_CYC = (DATA_VALID_NS / CLK_PERIOD_NS < 1) ? 1
                                           : DATA_VALID_NS / CLK_PERIOD_NS;
    localparam int          ADDR_WIN_NS   = 25;
    localparam int          ADDR_WIN_CYC  = (ADDR_WIN_NS / CLK_PERIOD_NS < 1) ? 1
                                           : ADDR_WIN_NS / CLK_PERIOD_NS;
    localparam logic [4:0]  REPLY_DLY     = 5'h02;
    localparam int          CSR_ADDR_LSB  = 1;
    localparam int          CSR_ADDR_MSB  = 12;
    localparam int          EXT_LSB       = 18;
    localparam int          EXT_MSB       = 21;
    localparam int          PAR_ERR_LINE  = 16;
    localparam int          ERR_EN_LINE   = 17;
    localparam int          CSR_FORCE_BIT = 2;
    localparam int          CSR_ERR_BIT   = 15;
    localparam int          BYTE_SEL_BIT  = 0;
    localparam logic [15:0] CSR_RESET     = 16'h0000;
    localparam logic [17:0] DAL_ZERO      = 18'h00000;

    typedef enum logic [4:0] {
        BMS_IDLE  = 5'b00001,
        BMS_ADDR  = 5'b00010,
        BMS_WAIT  = 5'b00100,
        BMS_REPLY = 5'b01000,
        BMS_DONE  = 5'b10000
    } bms_state_t;
endpackage : bms_pkg

// ---- bms_sync_if.sv ----
// Interface carrying synchronised bus control levels
`timescale 1ns/1ps
interface bms_sync_if;
    logic sync;
    logic din;
    logic dout;
    logic wtbt;
    logic bs7;
    logic dcok;
    logic init;
    modport src (output sync, din, dout, wtbt, bs7, dcok, init);
    modport dst (input  sync, din, dout, wtbt, bs7, dcok, init);
endinterface : bms_sync_if

// ---- bms_sync.sv ----
// Three-stage input synchroniser for the bus control lines
`timescale 1ns/1ps
module bms_sync (
    input  wire logic     clk_i,
    input  wire logic     rst_n_i,
    input  wire logic [6:0] raw_i,
    bms_sync_if.src       sif
);
    logic [6:0] s1;
    logic [6:0] s2;
    logic [6:0] s3;
    logic [6:0] stable;
    logic [6:0] next_stable;

    always_comb begin
        for (int i = 0; i < 7; i++) begin
            next_stable[i] = (s2[i] == s3[i]) ? s3[i] : stable[i];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s1     <= 7'h00;
            s2     <= 7'h00;
            s3     <= 7'h00;
            stable <= 7'h00;
        end else begin
            s1     <= raw_i;
            s2     <= s1;
            s3     <= s2;
            stable <= next_stable;
        end
    end

    assign sif.sync = stable[0];
    assign sif.din  = stable[1];
    assign sif.dout = stable[2];
    assign sif.wtbt = stable[3];
    assign sif.bs7  = stable[4];
    assign sif.dcok = stable[5];
    assign sif.init = stable[6];
endmodule : bms_sync

// ---- bms_slave.sv ----
// Slave bus interface of a memory card on a multiplexed backplane bus
`timescale 1ns/1ps
module bms_slave
    import bms_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              sync_n_i,
    input  wire logic              din_n_i,
    input  wire logic              dout_n_i,
    input  wire logic              wtbt_n_i,
    input  wire logic              bs7_n_i,
    input  wire logic              dcok_i,
    input  wire logic              init_n_i,
    input  wire logic [ADDR_W-1:0] dal_i,
    input  wire logic              ext_addr_en_i,
    input  wire logic [ADDR_W-1:0] start_addr_i,
    input  wire logic [ADDR_W-1:0] mem_size_i,
    input  wire logic [12:1]       csr_addr_i,
    input  wire logic              block_ok_i,
    output logic [17:0]            dal_o,
    output logic [17:0]            dal_oe_o,
    output logic                   rply_o,
    output logic                   ref_o,
    output logic                   par_err_led_o
);
    bms_sync_if sif ();
    logic [ADDR_W-1:0] dal_q1, dal_q2, dal_q3;
    logic [6:0]        raw_ctl;

    // Strobes turned active high before synchronising
    assign raw_ctl = {~init_n_i, dcok_i, ~bs7_n_i, ~wtbt_n_i, ~dout_n_i, ~din_n_i, ~sync_n_i};

    bms_sync u_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .raw_i   (raw_ctl),
        .sif     (sif)
    );

    bms_state_t        state, next_state;
    logic [ADDR_W-1:0] addr, next_addr;
    logic              is_write, next_is_write;
    logic              is_csr, next_is_csr;
    logic              byte_hi, next_byte_hi;
    logic              sync_d, next_sync_d;
    logic [4:0]        cnt, next_cnt;
    logic [15:0]       ctrl_status_register, next_csr;
    logic [17:0]       dal_r, next_dal_r;
    logic [17:0]       oe_r, next_oe_r;
    logic              rply_r, next_rply_r;
    logic              ref_r, next_ref_r;
    logic              led_r, next_led_r;

    // Word store and its per-byte parity bits
    logic [15:0]       mem [MEM_DEPTH];
    logic [1:0]        par [MEM_DEPTH];
    logic              wr_en;
    logic [15:0]       wr_word;
    logic [1:0]        wr_par;
    logic [MEM_AW-1:0] idx;
    logic              in_range;
    logic [ADDR_W-1:0] dec_addr;
    logic [ADDR_W-1:0] off;
    logic [1:0]        perr;

    // Address lines sampled three deep, one register fewer than the strobes (which also pass the stable stage)
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            dal_q1 <= '0;
            dal_q2 <= '0;
            dal_q3 <= '0;
        end else begin
            dal_q1 <= dal_i;
            dal_q2 <= dal_q1;
            dal_q3 <= dal_q2;
        end
    end

    // Range decode of the address captured at the strobe edge
    always_comb begin
        dec_addr = dal_q3;
        if (!ext_addr_en_i) begin
            dec_addr[EXT_MSB:EXT_LSB] = 4'h0;
        end
        off      = dec_addr - start_addr_i;
        in_range = (dec_addr >= start_addr_i) && (off < mem_size_i);
    end

    assign idx  = addr[MEM_AW:1];

    // Parity mismatch of the addressed word, one flag per byte
    assign perr = {^mem[idx][15:8] != par[idx][1], ^mem[idx][7:0] != par[idx][0]};

    // Transfer sequencer: next state and next outputs
    always_comb begin
        next_state    = state;
        next_addr     = addr;
        next_is_write = is_write;
        next_is_csr   = is_csr;
        next_byte_hi  = byte_hi;
        next_sync_d   = sif.sync;
        next_cnt      = cnt;
        next_csr      = ctrl_status_register;
        next_dal_r    = dal_r;
        next_oe_r     = oe_r;
        next_rply_r   = rply_r;
        next_ref_r    = ref_r;
        next_led_r    = led_r;
        wr_en         = 1'b0;
        wr_word       = mem[idx];
        wr_par        = par[idx];

        if (sif.init) begin
            next_csr = CSR_RESET;
        end

        case (state)
            BMS_IDLE: begin
                next_dal_r  = DAL_ZERO;
                next_oe_r   = DAL_ZERO;
                next_rply_r = 1'b0;
                next_ref_r  = 1'b0;
                if (sif.sync && !sync_d && sif.dcok) begin
                    // Address taken only at strobe's leading edge
                    next_addr     = dec_addr;
                    next_is_write = sif.wtbt;
                    next_byte_hi  = dal_q3[BYTE_SEL_BIT];
                    next_is_csr   = sif.bs7 &&
                        (dal_q3[CSR_ADDR_MSB:CSR_ADDR_LSB] == csr_addr_i);
                    next_cnt      = 5'h00;
                    if ((sif.bs7 && dal_q3[CSR_ADDR_MSB:CSR_ADDR_LSB] == csr_addr_i)
                        || (!sif.bs7 && in_range)) begin
                        next_state = BMS_WAIT;
                    end else begin
                        next_state = BMS_DONE;
                    end
                end
            end

            BMS_WAIT: begin
                // Cycle kind chosen from data strobes
                if (!sif.sync) begin
                    next_state = BMS_IDLE;
                end else if (!sif.dcok) begin
                    // Power lost mid-cycle: no answer at all
                    next_state = BMS_DONE;
                end else if (sif.din && !is_write) begin
                    next_dal_r[15:0] = is_csr ? ctrl_status_register : mem[idx];
                    if (!is_csr) begin
                        next_dal_r[PAR_ERR_LINE] = |perr;
                        next_dal_r[ERR_EN_LINE]  = ctrl_status_register[CSR_ERR_BIT] | (|perr);
                        if (|perr) begin
                            next_led_r = 1'b1;
                        end
                    end
                    next_oe_r   = 18'h3FFFF;
                    next_cnt    = 5'h00;
                    next_state  = BMS_REPLY;
                end else if (sif.dout) begin
                    if (is_csr) begin
                        next_csr = dal_q3[15:0];
                    end else begin
                        wr_en = 1'b1;
                        if (sif.wtbt) begin
                            if (byte_hi) begin
                                wr_word[15:8] = dal_q3[15:8];
                            end else begin
                                wr_word[7:0] = dal_q3[7:0];
                            end
                        end else begin
                            wr_word = dal_q3[15:0];
                        end
                        wr_par = {^wr_word[15:8], ^wr_word[7:0]} ^
                                 {2{ctrl_status_register[CSR_FORCE_BIT]}};
                    end
                    next_rply_r = 1'b1;
                    next_ref_r  = block_ok_i;
                    next_state  = BMS_DONE;
                end
            end

            BMS_REPLY: begin
                // Data driven first, reply follows well inside 125 ns
                next_cnt = cnt + 5'h01;
                if (cnt >= REPLY_DLY - 5'h01) begin
                    next_rply_r = 1'b1;
                    next_ref_r  = block_ok_i;
                end
                // Master has taken the data: stop driving
                if (!sif.din && rply_r) begin
                    next_rply_r = 1'b0;
                    next_oe_r   = DAL_ZERO;
                    next_state  = sif.bs7 ? BMS_WAIT : BMS_DONE;
                end
                if (!sif.sync) begin
                    next_rply_r = 1'b0;
                    next_oe_r   = DAL_ZERO;
                    next_state  = BMS_IDLE;
                end
            end

            BMS_DONE: begin
                // Writes and refused cycles wait for the strobes to go
                if (!sif.dout && !sif.din) begin
                    next_rply_r = 1'b0;
                    if (rply_r && sif.bs7) begin
                        next_state = BMS_WAIT;
                    end
                end
                if (!sif.sync) begin
                    next_rply_r = 1'b0;
                    next_oe_r   = DAL_ZERO;
                    next_state  = BMS_IDLE;
                end
            end

            default: begin
                next_state = BMS_IDLE;
            end
        endcase

        // Block flag only ever stands alongside the reply
        if (!next_rply_r) begin
            next_ref_r = 1'b0;
        end
    end

    // Sequencer registers
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state    <= BMS_IDLE;
            addr     <= '0;
            is_write <= 1'b0;
            is_csr   <= 1'b0;
            byte_hi  <= 1'b0;
            sync_d   <= 1'b0;
            cnt      <= 5'h00;
            ctrl_status_register      <= CSR_RESET;
            dal_r    <= DAL_ZERO;
            oe_r     <= DAL_ZERO;
            rply_r   <= 1'b0;
            ref_r    <= 1'b0;
            led_r    <= 1'b0;
        end else begin
            state    <= next_state;
            addr     <= next_addr;
            is_write <= next_is_write;
            is_csr   <= next_is_csr;
            byte_hi  <= next_byte_hi;
            sync_d   <= next_sync_d;
            cnt      <= next_cnt;
            ctrl_status_register      <= next_csr;
            dal_r    <= next_dal_r;
            oe_r     <= next_oe_r;
            rply_r   <= next_rply_r;
            ref_r    <= next_ref_r;
            led_r    <= next_led_r;
        end
    end

    // Storage array, no reset
    always_ff @(posedge clk_i) begin
        if (wr_en) begin
            mem[idx] <= wr_word;
            par[idx] <= wr_par;
        end
    end

    // Outputs straight from flip-flops
    assign dal_o         = dal_r;
    assign dal_oe_o      = oe_r;
    assign rply_o        = rply_r;
    assign ref_o         = ref_r;
    assign par_err_led_o = led_r;
endmodule : bms_slave

// ---- bms_slave_asserts.sv ----
// Port-level checks of the backplane memory slave interface
`timescale 1ns/1ps
module bms_slave_asserts (
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic        sync_n_i,
    input wire logic        din_n_i,
    input wire logic        dout_n_i,
    input wire logic        dcok_i,
    input wire logic        block_ok_i,
    input wire logic [17:0] dal_o,
    input wire logic [17:0] dal_oe_o,
    input wire logic        rply_o,
    input wire logic        ref_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_unpowered;
        !dcok_i && $fell(sync_n_i) |-> !rply_o [*8];
    endproperty
    a_unpowered: assert property (p_unpowered)
        else $error("reply while power is not good");
    property p_idle;
        sync_n_i [*8] |-> !rply_o && dal_oe_o == 18'h00000;
    endproperty
    a_idle: assert property (p_idle)
        else $error("lines or reply held after strobe release");
    property p_rply_cause;
        $rose(rply_o) |-> !sync_n_i && (!din_n_i || !dout_n_i);
    endproperty
    a_rply_cause: assert property (p_rply_cause)
        else $error("reply without a transfer request");
    property p_rd_drive;
        $rose(rply_o) && !din_n_i |-> dal_oe_o[15:0] == 16'hFFFF;
    endproperty
    a_rd_drive: assert property (p_rd_drive)
        else $error("read reply without data driven");
    property p_rd_hold;
        rply_o && $past(rply_o) && !din_n_i |-> $stable(dal_o[15:0]);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data changed during reply");
    property p_ref;
        !rply_o |-> !ref_o;
    endproperty
    a_ref: assert property (p_ref)
        else $error("block flag outside reply");
    property p_ref_blk;
        $rose(rply_o) |-> ref_o == $past(block_ok_i);
    endproperty
    a_ref_blk: assert property (p_ref_blk)
        else $error("block flag does not follow block acceptance at reply");
    property p_err_en;
        dal_oe_o[16] && dal_o[16] |-> dal_oe_o[17] && dal_o[17];
    endproperty
    a_err_en: assert property (p_err_en)
        else $error("parity error without error enable");
    property p_oe_cause;
        $rose(dal_oe_o[0]) |-> !din_n_i && !sync_n_i;
    endproperty
    a_oe_cause: assert property (p_oe_cause)
        else $error("lines driven outside a read");
endmodule : bms_slave_asserts

// ---- bms_mstr.sv ----
// Behavioural bus master for the backplane memory slave interface
`timescale 1ns/1ps
module bms_mstr
    import bms_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rply_i,
    input  wire logic [17:0] dal_i,
    output logic             sync_n_o,
    output logic             din_n_o,
    output logic             dout_n_o,
    output logic             wtbt_n_o,
    output logic             bs7_n_o,
    output logic [21:0]      dal_o
);
    initial begin
        sync_n_o = 1'b1;
        din_n_o  = 1'b1;
        dout_n_o = 1'b1;
        wtbt_n_o = 1'b1;
        bs7_n_o  = 1'b1;
        dal_o    = 22'h000000;
    end
    task automatic xfer(input logic [21:0] a, input logic rd, input logic by,
                        input logic io, input logic [15:0] wd,
                        output logic [17:0] q, output logic ok);
        int n;
        n = 0;
        q = 'x;
        dal_o    <= a;
        wtbt_n_o <= rd;
        bs7_n_o  <= !io;
        repeat (5) @(posedge clk_i);
        sync_n_o <= 1'b0;
        repeat (2) @(posedge clk_i);
        dal_o    <= rd ? ~a : {6'h00, wd};
        wtbt_n_o <= !by;
        bs7_n_o  <= 1'b1;
        @(posedge clk_i);
        din_n_o  <= !rd;
        dout_n_o <= rd;
        do begin
            @(posedge clk_i);
            n++;
        end while (!rply_i && n < 40);
        ok = rply_i;
        if (rd && ok) begin
            repeat (DATA_VALID_CYC) @(posedge clk_i);
            q = dal_i;
        end
        din_n_o  <= 1'b1;
        dout_n_o <= 1'b1;
        wtbt_n_o <= 1'b1;
        dal_o    <= ~dal_o;
        n = 0;
        while (rply_i && n < 40) begin
            @(posedge clk_i);
            n++;
        end
        sync_n_o <= 1'b1;
        repeat (8) @(posedge clk_i);
    endtask : xfer
    task automatic rd_blk(input logic [21:0] a, output logic [17:0] q0,
                          output logic [17:0] q1);
        int n;
        n = 0;
        q0 = 'x;
        q1 = 'x;
        dal_o    <= a;
        wtbt_n_o <= 1'b1;
        repeat (5) @(posedge clk_i);
        sync_n_o <= 1'b0;
        repeat (2) @(posedge clk_i);
        dal_o    <= ~a;
        bs7_n_o  <= 1'b0;
        for (int k = 0; k < 2; k++) begin
            @(posedge clk_i);
            din_n_o <= 1'b0;
            if (k == 1) begin
                bs7_n_o <= 1'b1;
            end
            n = 0;
            do begin
                @(posedge clk_i);
                n++;
            end while (!rply_i && n < 40);
            if (rply_i) begin
                repeat (DATA_VALID_CYC) @(posedge clk_i);
                if (k == 0) begin
                    q0 = dal_i;
                end else begin
                    q1 = dal_i;
                end
            end
            din_n_o <= 1'b1;
            n = 0;
            while (rply_i && n < 40) begin
                @(posedge clk_i);
                n++;
            end
        end
        sync_n_o <= 1'b1;
        repeat (8) @(posedge clk_i);
    endtask : rd_blk
endmodule : bms_mstr

// ---- bms_slave_test.sv ----
// Self-checking testbench of the backplane memory slave interface
`timescale 1ns/1ps
module bms_slave_test;
    import bms_pkg::*;
    localparam logic [21:0] START = 22'h002000;
    localparam logic [21:0] SIZE  = 22'h000200;
    localparam logic [21:0] CSR_A = 22'h000F68;
    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        dcok_i = 1'b1;
    logic        init_n_i = 1'b1;
    logic        ext_en = 1'b0;
    logic        blk_ok = 1'b0;
    logic        sync_n_i, din_n_i, dout_n_i, wtbt_n_i, bs7_n_i;
    logic        rply_o, ref_o, par_err_led_o, ok;
    logic [21:0] dal_i;
    logic [17:0] dal_o, dal_oe_o, q, q2;
    logic [15:0] mem [256];
    logic [31:0] seed = 32'hBE7E;
    logic [31:0] v;
    int          n_errors = 0;
    int          check_count = 0;
    int          cyc = 0;
    always #12.5 clk_i = ~clk_i;
    bms_slave dut_u (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .sync_n_i(sync_n_i), .din_n_i(din_n_i),
        .dout_n_i(dout_n_i), .wtbt_n_i(wtbt_n_i), .bs7_n_i(bs7_n_i), .dcok_i(dcok_i),
        .init_n_i(init_n_i), .dal_i(dal_i), .ext_addr_en_i(ext_en), .start_addr_i(START),
        .mem_size_i(SIZE), .csr_addr_i(CSR_A[12:1]), .block_ok_i(blk_ok), .dal_o(dal_o),
        .dal_oe_o(dal_oe_o), .rply_o(rply_o), .ref_o(ref_o), .par_err_led_o(par_err_led_o)
    );
    bms_mstr mstr_u (
        .clk_i(clk_i), .rply_i(rply_o), .dal_i(dal_o), .sync_n_o(sync_n_i),
        .din_n_o(din_n_i), .dout_n_o(dout_n_i), .wtbt_n_o(wtbt_n_i), .bs7_n_o(bs7_n_i),
        .dal_o(dal_i)
    );
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [15:0] merge(logic [15:0] o, logic [15:0] d, logic by, logic hi);
        if (!by) return d;
        return hi ? {d[15:8], o[7:0]} : {o[15:8], d[7:0]};
    endfunction : merge
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic test_done();
        $display("checks=%0d errors=%0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done
    task automatic wr(input logic [21:0] a, input logic by, input logic [15:0] d);
        mstr_u.xfer(a, 1'b0, by, 1'b0, d, q, ok);
        chk({17'h0, ok}, 18'h00001);
        mem[a[8:1]] = merge(mem[a[8:1]], d, by, a[0]);
    endtask : wr
    task automatic rd(input logic [21:0] a, input logic [1:0] pe);
        mstr_u.xfer(a, 1'b1, 1'b0, 1'b0, 16'h0000, q, ok);
        chk(q, {pe, mem[a[8:1]]});
    endtask : rd
    task automatic none(input logic [21:0] a, input logic io);
        mstr_u.xfer(a, 1'b0, 1'b0, io, 16'h5A5A, q, ok);
        chk({17'h0, ok}, 18'h00000);
    endtask : none
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_errors++;
            test_done();
        end
    end
    initial begin
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        for (int i = 0; i < 256; i++) begin
            v = rnd();
            blk_ok <= v[30];
            wr(START + {13'h0, i[7:0], 1'b0}, 1'b0, v[15:0]);
        end
        for (int i = 0; i < 16; i++) begin
            v = rnd();
            wr(START + {13'h0, v[8:0]}, 1'b1, v[31:16]);
            rd(START + {13'h0, v[8:1], 1'b0}, 2'b00);
        end
        $display("test data done");
        blk_ok <= 1'b1;
        mstr_u.rd_blk(START + 22'h6, q, q2);
        chk(q, {2'b00, mem[8'h03]});
        chk(q2, {2'b00, mem[8'h03]});
        rd(START, 2'b00);
        rd(START + SIZE - 22'h2, 2'b00);
        none(START - 22'h2, 1'b0);
        none(START + SIZE, 1'b0);
        none(CSR_A ^ 22'h2, 1'b1);
        dcok_i <= 1'b0;
        none(START, 1'b0);
        dcok_i <= 1'b1;
        wr(22'h042010, 1'b0, 16'hC3C3);
        rd(22'h002010, 2'b00);
        ext_en <= 1'b1;
        none(22'h042010, 1'b0);
        $display("test select done");
        mstr_u.xfer(CSR_A, 1'b0, 1'b0, 1'b1, 16'h0004, q, ok);
        chk({17'h0, ok}, 18'h00001);
        wr(START + 22'h4, 1'b0, 16'h0F0F);
        rd(START + 22'h4, 2'b11);
        chk({17'h0, par_err_led_o}, 18'h00001);
        init_n_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        init_n_i <= 1'b1;
        mstr_u.xfer(CSR_A, 1'b1, 1'b0, 1'b1, 16'h0000, q, ok);
        chk({2'b00, q[15:0]}, {2'b00, CSR_RESET});
        wr(START + 22'h4, 1'b0, 16'hF0F0);
        rd(START + 22'h4, 2'b00);
        $display("test register done");
        test_done();
    end
endmodule : bms_slave_test
bind bms_slave bms_slave_asserts chk_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .sync_n_i(sync_n_i), .din_n_i(din_n_i),
    .dout_n_i(dout_n_i), .dcok_i(dcok_i), .block_ok_i(block_ok_i), .dal_o(dal_o),
    .dal_oe_o(dal_oe_o),
    .rply_o(rply_o), .ref_o(ref_o)
);
